// File: verilog/sram_pkg.sv
// Constants and types for the synchronous burst SRAM port
package sram_pkg;
   // Array shape
   localparam int ADDR_W = 15;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORD_W = LANES * LANE_W;
   localparam int DEPTH = 32768;
   typedef logic [WORD_W-1:0] word_t;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [ADDR_W-3:0] base_t;
   typedef logic [LANES-1:0] lanes_t;
   // Register map and fields
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam int CTRL_EN_POS = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int STAT_ADDR_POS = 0;
   localparam int STAT_CNT_POS = 16;
   localparam int STAT_STATE_POS = 20;
   localparam int STAT_ORDER_POS = 24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Burst counter reset value
   localparam logic [1:0] CNT_RST = 2'h0;
   // Kind of the cycle in progress
   typedef enum logic [2:0] {
      ST_DESEL = 3'h1,
      ST_READ = 3'h2,
      ST_WRITE = 3'h4
   } cycle_e;
   // Decision taken at a clock edge
   typedef struct packed {
      logic active;
      logic write;
      addr_t addr;
      lanes_t lanes;
   } cycle_s;
endpackage

// File: verilog/sync_burst_sram_port.sv
// Synchronous flow-through burst SRAM with an AXI4-Lite control port
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_port (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   input wire sram_pkg::base_t address_inputs_i,
   input wire logic burst_low_bit_one_i,
   input wire logic burst_low_bit_zero_i,
   input wire logic proc_addr_strobe_n_i,
   input wire logic ctrl_addr_strobe_n_i,
   input wire logic burst_step_n_i,
   input wire logic chip_enable_first_n_i,
   input wire logic chip_enable_second_i,
   input wire logic chip_enable_third_n_i,
   input wire logic all_bytes_write_n_i,
   input wire logic byte_write_gate_n_i,
   input wire sram_pkg::lanes_t lane_write_n_i,
   input wire logic output_enable_n_i,
   input wire logic burst_order_select_i,
   input wire sram_pkg::word_t data_lanes_i,
   output logic [sram_pkg::WORD_W-1:0] data_lanes_o,
   output logic data_lanes_oe_o,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import sram_pkg::*;

   // Array index width and lane split must agree with the word shape
   if (DEPTH != (1 << ADDR_W) || WORD_W != LANES * LANE_W) begin : g_shape_bad
      $error("array shape does not fit the address and lane widths");
   end

   logic strobe_p, strobe_c, load_w, step_w, chip_on_w, wr_req_w;
   lanes_t lane_en_w;
   base_t base_ff, nxt_base;
   logic [1:0] start_ff, nxt_start, count_ff, nxt_count, low_w;
   addr_t addr_ff;
   cycle_e state_ff, nxt_state;
   cycle_s nxt_cyc;
   logic ctrl_en_ff;
   logic aw_full_ff, w_full_ff, awrdy_ff, wrdy_ff, bvalid_ff, arrdy_ff, rvalid_ff;
   logic nxt_aw_full, nxt_w_full, nxt_bvalid, nxt_rvalid, do_wr;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff, stat_w;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;

   // Strobe qualification and chip select
   assign strobe_p = !proc_addr_strobe_n_i && !chip_enable_first_n_i;
   assign strobe_c = !ctrl_addr_strobe_n_i;
   assign load_w = strobe_p || strobe_c;
   assign step_w = !burst_step_n_i;
   assign chip_on_w = !chip_enable_first_n_i && chip_enable_second_i
      && !chip_enable_third_n_i && ctrl_en_ff;

   // Write detection and lane enables
   assign wr_req_w = !all_bytes_write_n_i
      || (!byte_write_gate_n_i && !(&lane_write_n_i));
   always_comb begin
      if (!all_bytes_write_n_i) begin
         lane_en_w = '1;
      end else if (!byte_write_gate_n_i) begin
         lane_en_w = ~lane_write_n_i;
      end else begin
         lane_en_w = '0;
      end
   end

   // Next address and cycle kind from strobes, step and order
   always_comb begin
      nxt_base = base_ff;
      nxt_start = start_ff;
      nxt_count = count_ff;
      nxt_cyc.active = (state_ff != ST_DESEL);
      nxt_cyc.write = wr_req_w;
      if (load_w) begin
         nxt_base = address_inputs_i;
         nxt_start = {burst_low_bit_one_i, burst_low_bit_zero_i};
         nxt_count = CNT_RST;
         nxt_cyc.active = chip_on_w;
         nxt_cyc.write = strobe_p ? 1'b0 : wr_req_w;
      end else if (step_w) begin
         nxt_count = count_ff + 2'h1;
      end
      if (burst_order_select_i) begin
         low_w = nxt_start ^ nxt_count;
      end else begin
         low_w = nxt_start + nxt_count;
      end
      nxt_cyc.addr = {nxt_base, low_w};
      nxt_cyc.lanes = (nxt_cyc.active && nxt_cyc.write) ? lane_en_w : '0;
   end

   // Cycle kind decoder
   always_comb begin
      case ({nxt_cyc.active, nxt_cyc.write})
         2'b10: nxt_state = ST_READ;
         2'b11: nxt_state = ST_WRITE;
         default: nxt_state = ST_DESEL;
      endcase
   end

   // Input capture of address, counter and cycle kind
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         base_ff <= '0;
         start_ff <= CNT_RST;
         count_ff <= CNT_RST;
         addr_ff <= '0;
         state_ff <= ST_DESEL;
      end else if (clk_en_i) begin
         base_ff <= nxt_base;
         start_ff <= nxt_start;
         count_ff <= nxt_count;
         addr_ff <= nxt_cyc.addr;
         state_ff <= nxt_state;
      end
   end

   // One array and read flop per byte lane
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] mem [DEPTH];
      logic [LANE_W-1:0] rd_ff;
      // Self-timed write at the sampling edge
      always_ff @(posedge clock_i) begin
         if (clk_en_i && nxt_cyc.lanes[g]) begin
            mem[nxt_cyc.addr] <= data_lanes_i[g*LANE_W +: LANE_W];
         end
      end
      // Array word captured at the same edge as its address
      always_ff @(posedge clock_i or negedge nrst_i) begin
         if (!nrst_i) begin
            rd_ff <= '0;
         end else if (clk_en_i && nxt_state == ST_READ) begin
            rd_ff <= mem[nxt_cyc.addr];
         end
      end
      assign data_lanes_o[g*LANE_W +: LANE_W] = rd_ff;
   end

   // Pin drive follows the enable without a clock
   assign data_lanes_oe_o = (state_ff == ST_READ) && !output_enable_n_i;

   // AXI write channel handshakes
   assign do_wr = aw_full_ff && w_full_ff && !bvalid_ff;
   assign nxt_aw_full = (aw_full_ff && !do_wr) || (awrdy_ff && s_axi_awvalid);
   assign nxt_w_full = (w_full_ff && !do_wr) || (wrdy_ff && s_axi_wvalid);
   assign nxt_bvalid = do_wr || (bvalid_ff && !s_axi_bready);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         awrdy_ff <= 1'b0;
         wrdy_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bresp_ff <= RESP_OKAY;
      end else if (clk_en_i) begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff <= nxt_w_full;
         bvalid_ff <= nxt_bvalid;
         awrdy_ff <= !nxt_aw_full && !nxt_bvalid;
         wrdy_ff <= !nxt_w_full && !nxt_bvalid;
         if (awrdy_ff && s_axi_awvalid) begin
            awaddr_ff <= s_axi_awaddr;
         end
         if (wrdy_ff && s_axi_wvalid) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_wr) begin
            bresp_ff <= (awaddr_ff == CTRL_OFS || awaddr_ff == STATUS_OFS)
               ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Control register, its enable gates chip selection
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_en_ff <= CTRL_EN_RST;
      end else if (clk_en_i && do_wr && awaddr_ff == CTRL_OFS && wstrb_ff[0]) begin
         ctrl_en_ff <= wdata_ff[CTRL_EN_POS];
      end
   end

   // Status word shows the live burst state
   always_comb begin
      stat_w = '0;
      stat_w[STAT_ADDR_POS +: ADDR_W] = addr_ff;
      stat_w[STAT_CNT_POS +: 2] = count_ff;
      stat_w[STAT_STATE_POS +: 3] = state_ff;
      stat_w[STAT_ORDER_POS] = burst_order_select_i;
   end

   // AXI read channel
   assign nxt_rvalid = (arrdy_ff && s_axi_arvalid) || (rvalid_ff && !s_axi_rready);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         arrdy_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (clk_en_i) begin
         rvalid_ff <= nxt_rvalid;
         arrdy_ff <= !nxt_rvalid;
         if (arrdy_ff && s_axi_arvalid) begin
            rresp_ff <= RESP_OKAY;
            if (s_axi_araddr == CTRL_OFS) begin
               rdata_ff <= {31'h0, ctrl_en_ff};
            end else if (s_axi_araddr == STATUS_OFS) begin
               rdata_ff <= stat_w;
            end else begin
               rdata_ff <= '0;
               rresp_ff <= RESP_SLVERR;
            end
         end
      end
   end

   // Bus outputs
   assign s_axi_awready = awrdy_ff;
   assign s_axi_wready = wrdy_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arrdy_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // Checks on burst sequencing and data flow
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_lin_load;
      clk_en_i && load_w && !burst_order_select_i;
   endsequence
   sequence s_plain_step;
      clk_en_i && step_w && !load_w;
   endsequence
   sequence s_same_read;
      clk_en_i && nxt_state == ST_READ && nxt_cyc.addr == $past(nxt_cyc.addr);
   endsequence

   chk_lin_step: assert property (
      s_plain_step and (!burst_order_select_i)
      |=> addr_ff[1:0] == 2'($past(addr_ff[1:0]) + 2'h1))
      else $error("linear step did not add one");
   chk_lin_wrap: assert property (
      s_lin_load ##1 s_plain_step [*4]
      |=> addr_ff[1:0] == $past(addr_ff[1:0], 4))
      else $error("linear burst did not wrap after four");
   chk_inter_step: assert property (
      s_plain_step and burst_order_select_i
      |=> addr_ff[1:0] == ($past(addr_ff[1:0]) ^ $past(count_ff)
         ^ 2'($past(count_ff) + 2'h1)))
      else $error("interleaved step wrong");
   chk_addr_hold: assert property (
      clk_en_i && !load_w && !step_w |=> $stable(addr_ff))
      else $error("address moved without strobe or step");
   chk_ext_load: assert property (
      clk_en_i && load_w |=> addr_ff == $past({address_inputs_i,
         burst_low_bit_one_i, burst_low_bit_zero_i}))
      else $error("strobe did not load external address");
   chk_proc_block: assert property (
      clk_en_i && chip_enable_first_n_i && !proc_addr_strobe_n_i
      && ctrl_addr_strobe_n_i && state_ff != ST_DESEL |=> state_ff != ST_DESEL)
      else $error("blocked processor strobe deselected");
   chk_ctrl_desel: assert property (
      clk_en_i && strobe_c && !strobe_p && !chip_on_w
      |=> state_ff == ST_DESEL && !data_lanes_oe_o)
      else $error("controller strobe did not deselect");
   chk_oe_async: assert property (
      output_enable_n_i |-> !data_lanes_oe_o)
      else $error("data driven while output enable high");
   chk_gw_lanes: assert property (
      clk_en_i && !all_bytes_write_n_i |-> lane_en_w == '1)
      else $error("global write missed a lane");
   chk_flow_read: assert property (
      (clk_en_i && nxt_cyc.lanes == '1) ##1 s_same_read
      |=> data_lanes_o == $past(data_lanes_i, 2))
      else $error("written word not read back");
   chk_lane_a: assert property (
      (clk_en_i && nxt_cyc.lanes[0]) ##1 s_same_read
      |=> data_lanes_o[LANE_W-1:0] == $past(data_lanes_i[LANE_W-1:0], 2))
      else $error("lane a not written");
   chk_proc_read: assert property (
      clk_en_i && strobe_p && chip_on_w |=> state_ff == ST_READ)
      else $error("processor strobe did not begin a read");
   chk_clk_freeze: assert property (
      !clk_en_i |=> $stable(addr_ff) && $stable(state_ff) && $stable(data_lanes_o))
      else $error("state moved while the clock enable was low");
   chk_write_float: assert property (
      state_ff == ST_WRITE |-> !data_lanes_oe_o)
      else $error("data driven during a write cycle");
   chk_desel_stays: assert property (
      clk_en_i && !load_w && state_ff == ST_DESEL |=> state_ff == ST_DESEL)
      else $error("deselected chip woke without a strobe");
endmodule
`default_nettype wire

// File: tb/cache_ctrl_model.sv
// Cache controller model that drives the SRAM side of the port
`timescale 1ns/1ps
`default_nettype none
module cache_ctrl_model (
   input wire logic clock_i,
   output var sram_pkg::addr_t a_o,
   output logic ps_n_o,
   output logic cs_n_o,
   output logic st_n_o,
   output logic [2:0] e_o,
   output logic [5:0] w_o,
   output logic oe_n_o,
   output var sram_pkg::word_t d_o
);
   import sram_pkg::*;
   // Quiet bus at time zero, chip selected but no strobe
   initial {ps_n_o, cs_n_o, st_n_o, oe_n_o, w_o, e_o, a_o, d_o} = {13'h1ffa, 51'h0};
   // One cycle: k 1 controller strobe, 2 processor strobe, 3 step, else hold
   task automatic op(input int k, input addr_t a, input logic [6:0] w, input logic [2:0] e,
      input word_t d);
      logic wr;
      wr = !w[5] || (!w[4] && w[3:0] != 4'hf);
      @(posedge clock_i);
      ps_n_o <= k != 2;
      cs_n_o <= k != 1;
      st_n_o <= k != 3;
      a_o <= a;
      e_o <= e;
      w_o <= w[5:0];
      oe_n_o <= wr | w[6];
      d_o <= wr ? d : ~d_o; // Idle data lines never keep the old value
      @(negedge clock_i);
   endtask
endmodule
`default_nettype wire

// File: tb/sync_burst_sram_port_test.sv
// Self-checking bench for the burst SRAM port against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_port_test;
   import sram_pkg::*;
   logic clock_i, nrst_i, clk_en, order, en, exp_v;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire word_t dout, pd, dq;
   wire addr_t pa;
   wire logic [2:0] pe;
   wire logic [5:0] pw;
   wire logic ps_n, cs_n, st_n, oe_n, doe;
   int error_cnt, n_tests, st, cnt;
   addr_t ba = '0, cur = '0;
   word_t exp_q, mem[int];
   cache_ctrl_model p (.clock_i, .a_o(pa), .ps_n_o(ps_n), .cs_n_o(cs_n), .st_n_o(st_n),
      .e_o(pe), .w_o(pw), .oe_n_o(oe_n), .d_o(pd));
   sync_burst_sram_port dut (.clock_i, .nrst_i, .clk_en_i(clk_en), .address_inputs_i(pa[14:2]),
      .burst_low_bit_one_i(pa[1]), .burst_low_bit_zero_i(pa[0]), .proc_addr_strobe_n_i(ps_n),
      .ctrl_addr_strobe_n_i(cs_n), .burst_step_n_i(st_n), .chip_enable_first_n_i(pe[2]),
      .chip_enable_second_i(pe[1]), .chip_enable_third_n_i(pe[0]), .all_bytes_write_n_i(pw[5]),
      .byte_write_gate_n_i(pw[4]), .lane_write_n_i(pw[3:0]), .output_enable_n_i(oe_n),
      .burst_order_select_i(order), .data_lanes_i(dq), .data_lanes_o(dout),
      .data_lanes_oe_o(doe), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // 40 MHz bench clock
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   // Data wire resolved from both drivers
   assign dq = doe ? dout : pd;
   // Compare one value and count it
   task automatic chk(input logic [35:0] s, input logic [35:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Print the verdict and stop
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One register transfer, a write when wr is high
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
      @(posedge clock_i);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
      for (int n = 0; n < 50; n++) begin
         @(posedge clock_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (wr ? s_axi_bvalid : s_axi_rvalid) begin
            {q, r} = wr ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
            {s_axi_bready, s_axi_rready} <= 2'b00;
            return;
         end
      end
      error_cnt++;
      complete_run();
   endtask
   // Drive one SRAM cycle, check the one before, then advance the model
   task automatic go(input int k, input addr_t a, input logic [6:0] w, input logic [2:0] e,
      input word_t d);
      logic wr;
      word_t m;
      wr = !w[5] || (!w[4] && w[3:0] != 4'hf);
      p.op(k, a, w, e, d);
      if (exp_v) chk(dout, exp_q);
      chk(36'(doe), 36'(st == 1 && !oe_n));
      if (clk_en) begin
         if (k == 1 || (k == 2 && !e[2])) begin
            ba = a;
            cnt = 0;
            st = (e == 3'b010 && en) ? ((k == 2 || !wr) ? 1 : 2) : 0;
         end else begin
            cnt += int'(k == 3);
            if (st != 0) begin
               st = wr ? 2 : 1;
            end
         end
         cur = {ba[14:2], order ? ba[1:0] ^ cnt[1:0] : ba[1:0] + cnt[1:0]};
         m = mem.exists(cur) ? mem[cur] : '0;
         for (int j = 0; j < LANES; j++) begin
            if (st == 2 && (!w[5] || (!w[4] && !w[j]))) begin
               m[j*LANE_W +: LANE_W] = d[j*LANE_W +: LANE_W];
            end
         end
         if (st == 2) mem[cur] = m;
         exp_v = st == 1;
         exp_q = m;
      end
   endtask
   // Status word against the model
   task automatic stat;
      logic [31:0] q;
      logic [1:0] r;
      axi(1'b0, STATUS_OFS, '0, q, r);
      chk(36'({q[24], q[22:20], q[17:16], q[14:0]}), 36'({order,
         st == 1 ? ST_READ : st == 2 ? ST_WRITE : ST_DESEL, cnt[1:0], cur}));
   endtask
   // Main sequence
   initial begin
      logic [31:0] q;
      logic [1:0] r;
      addr_t a;
      {nrst_i, clk_en, order, en, exp_v} = 5'b01010;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      void'($urandom(70));
      repeat (6) @(posedge clock_i);
      nrst_i <= 1'b1;
      axi(1'b0, CTRL_OFS, '0, q, r);
      chk(36'({r, q}), 36'(CTRL_EN_RST));
      axi(1'b0, 8'h08, '0, q, r);
      chk(36'({r, q}), 36'({RESP_SLVERR, 32'h0}));
      axi(1'b1, STATUS_OFS, '1, q, r);
      chk(36'(r), 36'(RESP_OKAY));
      $display("Register test done");
      for (int o = 0; o < 2; o++) begin
         for (int s = 0; s < 4; s++) begin
            @(posedge clock_i) order <= o[0];
            a = addr_t'($urandom);
            a[1:0] = s[1:0];
            go(1, a, 7'h5f, 3'b010, word_t'({$urandom, $urandom}));
            repeat (3) go(3, '0, 7'h5f, 3'b010, word_t'({$urandom, $urandom}));
            go(1, a, 7'h3f, 3'b010, '0);
            repeat (4) go(3, '0, 7'h3f, 3'b010, '0);
            go(0, '0, 7'h7f, 3'b010, '0);
            stat();
            go(1, '0, 7'h7f, 3'b000, '0);
         end
      end
      $display("Burst test done");
      a = addr_t'($urandom);
      go(1, a, 7'h5f, 3'b010, '1);
      for (int m = 0; m < 17; m++) begin
         go(1, a, m < 16 ? {3'b110, m[3:0]} : 7'h4a, 3'b010, word_t'({$urandom, $urandom}));
         go(2, a, m == 0 ? 7'h5f : 7'h3f, 3'b010, '0);
      end
      $display("Lane test done");
      for (int e = 0; e < 8; e++) begin
         go(1, a, 7'h3f, e[2:0], '0);
         go(2, a, 7'h3f, e[2:0], '0);
      end
      go(1, a, 7'h3f, 3'b010, '0);
      go(2, a ^ 15'h1, 7'h3f, 3'b110, '0);
      axi(1'b1, CTRL_OFS, '0, q, r);
      chk(36'(r), 36'(RESP_OKAY));
      axi(1'b0, CTRL_OFS, '0, q, r);
      chk(36'({r, q}), 36'h0);
      en = 1'b0;
      go(1, a, 7'h3f, 3'b010, '0);
      go(2, a, 7'h3f, 3'b010, '0);
      go(0, '0, 7'h7f, 3'b010, '0);
      axi(1'b1, CTRL_OFS, 32'h1, q, r);
      chk(36'(r), 36'(RESP_OKAY));
      en = 1'b1;
      $display("Enable test done");
      go(1, a, 7'h3f, 3'b010, '0);
      go(0, '0, 7'h3f, 3'b010, '0);
      @(posedge clock_i) clk_en <= 1'b0;
      go(3, '0, 7'h3f, 3'b010, '0);
      go(0, '0, 7'h7f, 3'b010, '0);
      @(posedge clock_i) clk_en <= 1'b1;
      stat();
      $display("Control test done");
      complete_run();
   end
endmodule
`default_nettype wire
